// *** inc/por_ctrl_regs.svh ***
// Purpose: Register offsets, fields, reset values and timing constants
//          for the reset and clock-source control block.
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register.
// Notes:   Definitions only.
`ifndef POR_CTRL_REGS_SVH
`define POR_CTRL_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ADDR_W            8
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_OSC_TRIM      8'h08
`define REG_ULP_CAP_TRIM  8'h0C
`define REG_BOD_THRESH    8'h10

// ****************************************************************
// Control fields
// ****************************************************************
`define CTRL_XTAL_EN      0
`define CTRL_XTAL_32M     1
`define CTRL_OSC_SEL_LSB  2
`define CTRL_OSC_SEL_MSB  4
`define CTRL_BOD_FLAG     8
`define CTRL_SW_RESET     31

// ****************************************************************
// Status fields (BROWNOUT_DETECTOR event is write-one-to-clear)
// ****************************************************************
`define ST_BOD_EVENT      0
`define ST_OTP_DONE       1
`define ST_BOOTED         2
`define ST_LINE_LOW       3
`define ST_SEQ_LSB        4
`define ST_SEQ_MSB        5

// ****************************************************************
// Trim fields and reset values
// ****************************************************************
`define ULP_TRIM_MSB      7
`define CAP_TRIM_LSB      8
`define CAP_TRIM_MSB      13
`define OSC_TRIM_RST      32'h80808080
`define ULP_TRIM_RST      8'h80
`define CAP_TRIM_RST      6'h20
`define BOD_THR_W         4
`define BOD_THR_RST       4'h8

// ****************************************************************
// Bus responses and timing
// ****************************************************************
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`define RST_STRETCH_MS    50
`define SYS_CLK_KHZ       20000

`endif

// *** inc/por_ctrl_pkg.sv ***
// Purpose: Types shared by the reset and clock-source control block.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Numbers live in por_ctrl_regs.svh.
`default_nettype none

package por_ctrl_pkg;

	// Oscillator source selection
	typedef enum logic [2:0]
	{
		OSC_INT16  = 3'h0,
		OSC_INT20  = 3'h1,
		OSC_FAST44 = 3'h2,
		OSC_FAST84 = 3'h3,
		OSC_ULP400 = 3'h4,
		OSC_XTAL   = 3'h5
	} osc_sel_t;

	// Start-up sequence states
	typedef enum logic [1:0]
	{
		SEQ_RESET = 2'b00,
		SEQ_OTP   = 2'b01,
		SEQ_BOOT  = 2'b10,
		SEQ_RUN   = 2'b11
	} seq_state_t;

endpackage

`default_nettype wire

// *** hdl/reset_stretch_timer.sv ***
// Purpose: Counts the reset stretch time after the reset line rises.
// Assumes: hold_in is already synchronous to sys_clk_in.
// Notes:   done_out stays low while held and for CYCLES clocks after.
`include "por_ctrl_regs.svh"
`default_nettype none

module reset_stretch_timer #(
	parameter int unsigned CYCLES = `RST_STRETCH_MS * `SYS_CLK_KHZ
)(
	// Clock and reset
	input  wire logic sys_clk_in,
	input  wire logic rst_in,
	// Control and result
	input  wire logic hold_in,
	output logic      done_out
);

	localparam int unsigned CNT_W = $clog2(CYCLES + 1);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

	logic [CNT_W-1:0] cnt_r;

	// Restart on every hold, finish after the full count
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in || hold_in)
		begin
			cnt_r    <= '0;
			done_out <= 1'b0;
		end
		else if (cnt_r == LAST)
			done_out <= 1'b1;
		else
			cnt_r <= cnt_r + CNT_W'(1);
	end

endmodule

`default_nettype wire

// *** hdl/power_on_reset_and_clock_control.sv ***
// Purpose: Chip reset generation and clock-source control.
// Assumes: 20 MHz sys_clk_in, AXI4-Lite register access.
// Notes:   Trim, oscillator select and crystal divider survive chip reset; crystal enable does not.
`include "por_ctrl_regs.svh"
`default_nettype none

module power_on_reset_and_clock_control #(
	parameter int unsigned STRETCH_CYCLES = `RST_STRETCH_MS * `SYS_CLK_KHZ,
	parameter int unsigned BOD_COUNT      = 2
)(
	// Clock and reset
	input  wire logic                    sys_clk_in,
	input  wire logic                    rst_in,
	// Supply detectors
	input  wire logic                    main_supply_ok_in,
	input  wire logic [BOD_COUNT-1:0]    brownout_detector_in,
	output logic [`BOD_THR_W*BOD_COUNT-1:0] brownout_threshold_out,
	// Shared reset line
	input  wire logic                    chip_reset_line_n_in,
	output logic                         chip_reset_line_n_out,
	output logic                         chip_reset_line_n_oe_out,
	// Chip reset and start-up
	output logic                         chip_reset_out,
	output logic                         otp_load_req_out,
	input  wire logic                    otp_load_done_in,
	input  wire logic                    cpu_booted_in,
	// Clock control
	output logic                         crystal_enable_out,
	output logic                         crystal_div2_out,
	output logic [2:0]                   osc_select_out,
	output logic [31:0]                  osc_trim_out,
	output logic [7:0]                   ultra_low_power_osc_trim_out,
	output logic [5:0]                   crystal_cap_trim_out,
	// AXI4-Lite write channels
	input  wire logic [`ADDR_W-1:0]      s_axi_awaddr_in,
	input  wire logic                    s_axi_awvalid_in,
	output logic                         s_axi_awready_out,
	input  wire logic [31:0]             s_axi_wdata_in,
	input  wire logic [3:0]              s_axi_wstrb_in,
	input  wire logic                    s_axi_wvalid_in,
	output logic                         s_axi_wready_out,
	output logic [1:0]                   s_axi_bresp_out,
	output logic                         s_axi_bvalid_out,
	input  wire logic                    s_axi_bready_in,
	// AXI4-Lite read channels
	input  wire logic [`ADDR_W-1:0]      s_axi_araddr_in,
	input  wire logic                    s_axi_arvalid_in,
	output logic                         s_axi_arready_out,
	output logic [31:0]                  s_axi_rdata_out,
	output logic [1:0]                   s_axi_rresp_out,
	output logic                         s_axi_rvalid_out,
	input  wire logic                    s_axi_rready_in
);

	localparam int unsigned SYN_W = BOD_COUNT + 2;
	localparam int unsigned THR_W = `BOD_THR_W * BOD_COUNT;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [SYN_W-1:0]         s1_r;
	logic [SYN_W-1:0]         s2_r;
	logic [SYN_W-1:0]         s3_r;
	logic [SYN_W-1:0]         q_r;
	logic                     supply_ok;
	logic                     line_low;
	logic [BOD_COUNT-1:0]     bod_hit;
	logic                     stretch_done;
	logic                     rst_stage1_r;
	logic                     rst_stage2_r;
	logic                     vol_rst;
	logic                     bod_force;
	logic                     own_pull;
	por_ctrl_pkg::seq_state_t seq_r;
	por_ctrl_pkg::seq_state_t seq_nxt;
	logic                     otp_done_r;
	logic                     xtal_en_r;
	logic                     xtal_32m_r;
	logic [2:0]               osc_sel_r;
	logic                     bod_flag_only_r;
	logic                     sw_reset_r;
	logic                     bod_event_r;
	logic [31:0]              osc_trim_r;
	logic [7:0]               ulp_trim_r;
	logic [5:0]               cap_trim_r;
	logic [THR_W-1:0]         bod_thr_r;
	logic [`ADDR_W-1:0]       awaddr_r;
	logic [31:0]              wdata_r;
	logic [3:0]               wstrb_r;
	logic                     wr_en;
	logic                     wr_hit;
	logic [31:0]              wr_val;
	logic [31:0]              rd_mux;
	logic                     rd_hit;

	// Byte-lane merge of a write into an old register value
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[8*i +: 8] = new_v[8*i +: 8];
		end
		return res;
	endfunction

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************

	// Three stages; a change counts once stages two and three agree
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q_r  <= '0;
		end
		else
		begin
			s1_r <= {main_supply_ok_in, chip_reset_line_n_in,
				brownout_detector_in};
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r  <= (s2_r & s3_r) | (q_r & (s2_r | s3_r));
		end
	end

	assign supply_ok = q_r[SYN_W-1];
	assign line_low  = !q_r[SYN_W-2];
	assign bod_hit   = q_r[BOD_COUNT-1:0];

	// ****************************************************************
	// Reset line drive and stretching
	// ****************************************************************

	// Brownout forces reset unless software chose flag-only after start-up
	assign bod_force = (|bod_hit) &&
		(!bod_flag_only_r ||
		seq_r != por_ctrl_pkg::SEQ_RUN);

	// Own causes for pulling the line; only brownout can be masked
	assign own_pull = !supply_ok || bod_force || sw_reset_r;

	// Weak driver: low while a cause stands, high otherwise
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			chip_reset_line_n_out    <= 1'b0;
			chip_reset_line_n_oe_out <= 1'b1;
		end
		else
		begin
			chip_reset_line_n_out    <= !own_pull;
			chip_reset_line_n_oe_out <= 1'b1;
		end
	end

	// Stretch restarts on any qualified low, own or external
	reset_stretch_timer #(
		.CYCLES (STRETCH_CYCLES)
	) stretch_timer (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.hold_in    (line_low),
		.done_out   (stretch_done)
	);

	// Asserts at once on a low line; releases once line settled and stretched
	always_ff @(posedge sys_clk_in or negedge chip_reset_line_n_in)
	begin
		if (!chip_reset_line_n_in)
		begin
			rst_stage1_r <= 1'b1;
			rst_stage2_r <= 1'b1;
		end
		else if (rst_in)
		begin
			rst_stage1_r <= 1'b1;
			rst_stage2_r <= 1'b1;
		end
		else
		begin
			rst_stage1_r <= !stretch_done ||
				!(s2_r[SYN_W-2] && s3_r[SYN_W-2]);
			rst_stage2_r <= rst_stage1_r;
		end
	end

	assign chip_reset_out = rst_stage2_r;
	assign vol_rst        = rst_in || rst_stage2_r;

	// ****************************************************************
	// Start-up sequence
	// ****************************************************************

	// Next state from reset through OTP load and boot
	always_comb
	begin
		seq_nxt = seq_r;
		case (seq_r)
			por_ctrl_pkg::SEQ_RESET:
				seq_nxt = por_ctrl_pkg::SEQ_OTP;
			por_ctrl_pkg::SEQ_OTP:
				if (otp_load_done_in)
					seq_nxt = por_ctrl_pkg::SEQ_BOOT;
			por_ctrl_pkg::SEQ_BOOT:
				if (cpu_booted_in)
					seq_nxt = por_ctrl_pkg::SEQ_RUN;
			por_ctrl_pkg::SEQ_RUN:
				seq_nxt = por_ctrl_pkg::SEQ_RUN;
			default:
				seq_nxt = por_ctrl_pkg::SEQ_RESET;
		endcase
	end

	// Sequence state and OTP load request
	always_ff @(posedge sys_clk_in)
	begin
		if (vol_rst)
		begin
			seq_r            <= por_ctrl_pkg::SEQ_RESET;
			otp_load_req_out <= 1'b0;
			otp_done_r       <= 1'b0;
		end
		else
		begin
			seq_r            <= seq_nxt;
			otp_load_req_out <= (seq_nxt == por_ctrl_pkg::SEQ_OTP);
			if (seq_r == por_ctrl_pkg::SEQ_OTP && otp_load_done_in)
				otp_done_r <= 1'b1;
		end
	end

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************

	// Write address and data taken in either order
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out  <= 1'b1;
			s_axi_bvalid_out  <= 1'b0;
			s_axi_bresp_out   <= `RESP_OKAY;
			awaddr_r          <= '0;
			wdata_r           <= '0;
			wstrb_r           <= '0;
		end
		else
		begin
			if (s_axi_awvalid_in && s_axi_awready_out)
			begin
				awaddr_r          <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out)
			begin
				wdata_r          <= s_axi_wdata_in;
				wstrb_r          <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end
			if (wr_en)
			begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_bvalid_out && s_axi_bready_in)
			begin
				s_axi_bvalid_out  <= 1'b0;
				s_axi_awready_out <= 1'b1;
				s_axi_wready_out  <= 1'b1;
			end
		end
	end

	assign wr_en = !s_axi_awready_out && !s_axi_wready_out &&
		!s_axi_bvalid_out;

	// Write decode
	always_comb
	begin
		wr_hit = 1'b1;
		case (awaddr_r)
			`REG_CTRL:         wr_val = merge(rd_ctrl(), wdata_r, wstrb_r);
			`REG_STATUS:       wr_val = merge(32'h0, wdata_r, wstrb_r);
			`REG_OSC_TRIM:     wr_val = merge(osc_trim_r, wdata_r, wstrb_r);
			`REG_ULP_CAP_TRIM: wr_val = merge(rd_ulp(), wdata_r, wstrb_r);
			`REG_BOD_THRESH:   wr_val = merge(32'(bod_thr_r), wdata_r,
				wstrb_r);
			default:
			begin
				wr_val = 32'h0;
				wr_hit = 1'b0;
			end
		endcase
	end

	// Read data and response one clock after the address
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h0;
			s_axi_rresp_out   <= `RESP_OKAY;
		end
		else if (s_axi_arvalid_in && s_axi_arready_out)
		begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b1;
			s_axi_rdata_out   <= rd_mux;
			s_axi_rresp_out   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (s_axi_rvalid_out && s_axi_rready_in)
		begin
			s_axi_rvalid_out  <= 1'b0;
			s_axi_arready_out <= 1'b1;
		end
	end

	// Control word as software sees it
	function automatic logic [31:0] rd_ctrl();
		logic [31:0] v;
		v = 32'h0;
		v[`CTRL_XTAL_EN] = xtal_en_r;
		v[`CTRL_XTAL_32M] = xtal_32m_r;
		v[`CTRL_OSC_SEL_MSB:`CTRL_OSC_SEL_LSB] = osc_sel_r;
		v[`CTRL_BOD_FLAG] = bod_flag_only_r;
		v[`CTRL_SW_RESET] = sw_reset_r;
		return v;
	endfunction

	// Low-power oscillator and load capacitance trim word
	function automatic logic [31:0] rd_ulp();
		logic [31:0] v;
		v = 32'h0;
		v[`ULP_TRIM_MSB:0] = ulp_trim_r;
		v[`CAP_TRIM_MSB:`CAP_TRIM_LSB] = cap_trim_r;
		return v;
	endfunction

	// Read decode
	always_comb
	begin
		rd_mux = 32'h0;
		rd_hit = 1'b1;
		case (s_axi_araddr_in)
			`REG_CTRL:         rd_mux = rd_ctrl();
			`REG_STATUS:
			begin
				rd_mux[`ST_BOD_EVENT] = bod_event_r;
				rd_mux[`ST_OTP_DONE]  = otp_done_r;
				rd_mux[`ST_BOOTED]    = cpu_booted_in;
				rd_mux[`ST_LINE_LOW]  = line_low;
				rd_mux[`ST_SEQ_MSB:`ST_SEQ_LSB] = seq_r;
			end
			`REG_OSC_TRIM:     rd_mux = osc_trim_r;
			`REG_ULP_CAP_TRIM: rd_mux = rd_ulp();
			`REG_BOD_THRESH:   rd_mux = 32'(bod_thr_r);
			default:           rd_hit = 1'b0;
		endcase
	end

	// ****************************************************************
	// Registers
	// ****************************************************************

	// Persistent settings, cleared only at power-up
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			xtal_32m_r      <= 1'b0;
			osc_sel_r       <= por_ctrl_pkg::OSC_INT16;
			bod_flag_only_r <= 1'b0;
			osc_trim_r      <= `OSC_TRIM_RST;
			ulp_trim_r      <= `ULP_TRIM_RST;
			cap_trim_r      <= `CAP_TRIM_RST;
			bod_thr_r       <= {BOD_COUNT{`BOD_THR_RST}};
		end
		else if (wr_en && wr_hit)
		begin
			case (awaddr_r)
				`REG_CTRL:
				begin
					xtal_32m_r      <= wr_val[`CTRL_XTAL_32M];
					osc_sel_r       <=
						wr_val[`CTRL_OSC_SEL_MSB:`CTRL_OSC_SEL_LSB];
					bod_flag_only_r <= wr_val[`CTRL_BOD_FLAG];
				end
				`REG_OSC_TRIM:
					osc_trim_r <= wr_val;
				`REG_ULP_CAP_TRIM:
				begin
					ulp_trim_r <= wr_val[`ULP_TRIM_MSB:0];
					cap_trim_r <=
						wr_val[`CAP_TRIM_MSB:`CAP_TRIM_LSB];
				end
				`REG_BOD_THRESH:
					bod_thr_r <= wr_val[THR_W-1:0];
				default:
					bod_thr_r <= bod_thr_r;
			endcase
		end
	end

	// Volatile control, cleared by every chip reset
	always_ff @(posedge sys_clk_in)
	begin
		if (vol_rst)
		begin
			xtal_en_r  <= 1'b0;
			sw_reset_r <= 1'b0;
		end
		else if (wr_en && wr_hit && awaddr_r == `REG_CTRL)
		begin
			xtal_en_r  <= wr_val[`CTRL_XTAL_EN];
			sw_reset_r <= wr_val[`CTRL_SW_RESET];
		end
	end

	// Sticky brownout event; a new event beats a clear
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			bod_event_r <= 1'b0;
		else if (|bod_hit)
			bod_event_r <= 1'b1;
		else if (wr_en && awaddr_r == `REG_STATUS &&
			wr_val[`ST_BOD_EVENT])
			bod_event_r <= 1'b0;
	end

	// ****************************************************************
	// Clock-source outputs
	// ****************************************************************
	always_ff @(posedge sys_clk_in)
	begin
		if (vol_rst)
			crystal_enable_out <= 1'b0;
		else
			crystal_enable_out <= xtal_en_r && cpu_booted_in;
	end

	assign crystal_div2_out             = xtal_32m_r;
	assign osc_select_out               = osc_sel_r;
	assign osc_trim_out                 = osc_trim_r;
	assign ultra_low_power_osc_trim_out = ulp_trim_r;
	assign crystal_cap_trim_out         = cap_trim_r;
	assign brownout_threshold_out       = bod_thr_r;

endmodule

`default_nettype wire

// *** verification/por_ctrl_checker.sv ***
// Purpose: Port assertions for the reset and clock-source control block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Attached to the top module by bind.
`default_nettype none

module por_ctrl_checker #(
	parameter int unsigned STRETCH_CYCLES = 20,
	parameter int unsigned BOD_COUNT      = 2
)(
	// Clock and reset
	input wire logic                 sys_clk_in,
	input wire logic                 rst_in,
	// Watched ports
	input wire logic                 main_supply_ok_in,
	input wire logic [BOD_COUNT-1:0] brownout_detector_in,
	input wire logic                 chip_reset_line_n_in,
	input wire logic                 chip_reset_line_n_out,
	input wire logic                 chip_reset_out,
	input wire logic                 otp_load_req_out,
	input wire logic                 cpu_booted_in,
	input wire logic                 crystal_enable_out
);
	localparam int MAX_WAIT = STRETCH_CYCLES + 8;
	logic [31:0] hi_cnt_r;

	// Consecutive cycles the shared line has read high
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in || !chip_reset_line_n_in)
			hi_cnt_r <= 32'h0000_0000;
		else if (hi_cnt_r != 32'hFFFF_FFFF)
			hi_cnt_r <= hi_cnt_r + 32'h0000_0001;
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	a_line_low_reset: assert property (
		!chip_reset_line_n_in |-> chip_reset_out)
		else $error("chip reset not raised by low line");
	a_supply_pulls_line: assert property (
		!main_supply_ok_in [*5] |-> ##[0:2] !chip_reset_line_n_out)
		else $error("line not pulled low on supply loss");
	a_supply_resets_chip: assert property (
		!main_supply_ok_in [*8] |-> chip_reset_out)
		else $error("chip not in reset on supply loss");
	a_line_idle_high: assert property (
		(main_supply_ok_in && !(|brownout_detector_in) &&
		!chip_reset_out) [*8]
		|-> chip_reset_line_n_out)
		else $error("line not held high while idle");
	a_stretch_min: assert property (
		$fell(chip_reset_out) |-> hi_cnt_r >= STRETCH_CYCLES)
		else $error("chip reset released too early");
	a_stretch_max: assert property (
		hi_cnt_r == MAX_WAIT |-> !chip_reset_out)
		else $error("chip reset held too long");
	a_xtal_boot_gate: assert property (
		!cpu_booted_in |=> !crystal_enable_out)
		else $error("crystal enabled before boot");
	a_xtal_reset_off: assert property (
		chip_reset_out [*3] |=> !crystal_enable_out)
		else $error("crystal enabled during chip reset");
	a_bod_pulls_line: assert property (
		$rose(brownout_detector_in[0]) && chip_reset_out
		|-> ##[1:7] !chip_reset_line_n_out)
		else $error("brownout did not pull the line");
	a_otp_after_release: assert property (
		$fell(chip_reset_out) |-> ##[0:3] otp_load_req_out)
		else $error("no load request after release");

	// Main scenarios
	c_release: cover property ($fell(chip_reset_out));
	c_xtal_on: cover property ($rose(crystal_enable_out));
	c_ext_pull: cover property (!chip_reset_line_n_in && chip_reset_line_n_out);
endmodule

bind power_on_reset_and_clock_control por_ctrl_checker #(
	.STRETCH_CYCLES(STRETCH_CYCLES),
	.BOD_COUNT(BOD_COUNT)
) por_ctrl_checker_i (
	.sys_clk_in(sys_clk_in),
	.rst_in(rst_in),
	.main_supply_ok_in(main_supply_ok_in),
	.brownout_detector_in(brownout_detector_in),
	.chip_reset_line_n_in(chip_reset_line_n_in),
	.chip_reset_line_n_out(chip_reset_line_n_out),
	.chip_reset_out(chip_reset_out),
	.otp_load_req_out(otp_load_req_out),
	.cpu_booted_in(cpu_booted_in),
	.crystal_enable_out(crystal_enable_out)
);

`default_nettype wire

// *** verification/ext_reset_source.sv ***
// Purpose: Outside party sharing the active-low chip reset line.
// Assumes: Device drives the line weakly at both levels.
// Notes:   An undriven line wanders, as there is no pull resistor.
`default_nettype none

module ext_reset_source (
	// Clock and command
	input wire logic sys_clk_in,
	input wire logic pull_low_in,
	// Device weak drive
	input wire logic dev_level_in,
	input wire logic dev_oe_in,
	// Resolved line
	output logic     line_n_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic float_r = 1'b0;

	// Pattern shown on an undriven line
	always_ff @(posedge sys_clk_in)
		float_r <= !float_r;

	// Strong external low beats the weak device drive
	always_comb
	begin
		if (pull_low_in)
			line_n_out = 1'b0;
		else if (dev_oe_in)
			line_n_out = dev_level_in;
		else
			line_n_out = float_r;
	end
endmodule

`default_nettype wire

// *** verification/test_power_on_reset_and_clock_control.sv ***
// Purpose: Self-checking bench for the reset and clock-source control.
// Assumes: 20 MHz clock, shortened stretch count.
// Notes:   Register access over AXI4-Lite.
`include "por_ctrl_regs.svh"
`default_nettype none

module test_power_on_reset_and_clock_control;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int STRETCH = 20;
	logic sys_clk_in = 1'b0, rst_in = 1'b1, main_supply_ok_in = 1'b1;
	logic otp_load_done_in = 1'b0, cpu_booted_in = 1'b0, ext_pull = 1'b0;
	logic [1:0] brownout_detector_in = 2'h0;
	logic [7:0] brownout_threshold_out;
	logic chip_reset_line_n_in, chip_reset_line_n_out;
	logic chip_reset_line_n_oe_out, chip_reset_out, otp_load_req_out;
	logic crystal_enable_out, crystal_div2_out;
	logic [2:0] osc_select_out;
	logic [31:0] osc_trim_out, s_axi_rdata_out, s_axi_wdata_in = 32'h0;
	logic [7:0] ultra_low_power_osc_trim_out;
	logic [5:0] crystal_cap_trim_out;
	logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
	logic [3:0] s_axi_wstrb_in = 4'hF;
	logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
	logic s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0;
	logic s_axi_rready_in = 1'b0;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
	logic s_axi_arready_out, s_axi_rvalid_out;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
	logic [31:0] d;
	logic [1:0] r;
	int err_count = 0;
	int checks = 0;

	power_on_reset_and_clock_control #(.STRETCH_CYCLES(STRETCH),
		.BOD_COUNT(2)) power_on_reset_and_clock_control_i (.*);
	ext_reset_source ext_reset_source_i (.sys_clk_in(sys_clk_in),
		.pull_low_in(ext_pull), .dev_level_in(chip_reset_line_n_out),
		.dev_oe_in(chip_reset_line_n_oe_out),
		.line_n_out(chip_reset_line_n_in));

	// Clock
	always #25 sys_clk_in = ~sys_clk_in;

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask

	// Register write: address and data offered together
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= v;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		do
		begin
			@(posedge sys_clk_in);
			if (s_axi_awready_out)
				s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out)
				s_axi_wvalid_in <= 1'b0;
		end while (s_axi_bvalid_out !== 1'b1);
		r = s_axi_bresp_out;
		s_axi_bready_in <= 1'b0;
	endtask

	// Register read
	task automatic axi_rd(input logic [7:0] a);
		@(posedge sys_clk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		do
		begin
			@(posedge sys_clk_in);
			if (s_axi_arready_out)
				s_axi_arvalid_in <= 1'b0;
		end while (s_axi_rvalid_out !== 1'b1);
		d = s_axi_rdata_out;
		r = s_axi_rresp_out;
		s_axi_rready_in <= 1'b0;
	endtask

	// Wait for release, then load and boot
	task automatic reboot();
		while (chip_reset_out !== 1'b0)
			@(posedge sys_clk_in);
		otp_load_done_in <= 1'b1;
		cpu_booted_in <= 1'b1;
		cycles(4);
	endtask

	task automatic powerup_test();
		int hi;
		hi = 0;
		while (chip_reset_out !== 1'b0)
		begin
			@(posedge sys_clk_in);
			if (chip_reset_line_n_in === 1'b1)
				hi++;
		end
		check({31'h0, hi >= STRETCH && hi <= STRETCH + 8}, 32'h1);
		cycles(2);
		check(otp_load_req_out, 32'h1);
		otp_load_done_in <= 1'b1;
	endtask

	task automatic regs_test();
		axi_rd(`REG_OSC_TRIM);
		check(d, `OSC_TRIM_RST);
		axi_rd(`REG_ULP_CAP_TRIM);
		check(d, {18'h0, `CAP_TRIM_RST, `ULP_TRIM_RST});
		axi_rd(`REG_BOD_THRESH);
		check(d, {24'h0, `BOD_THR_RST, `BOD_THR_RST});
		axi_wr(`REG_OSC_TRIM, 32'h12345678);
		check(osc_trim_out, 32'h12345678);
		axi_wr(`REG_ULP_CAP_TRIM, 32'h00001555);
		check(crystal_cap_trim_out, 32'h15);
		check(ultra_low_power_osc_trim_out, 32'h55);
		axi_wr(`REG_BOD_THRESH, 32'h00000035);
		check(brownout_threshold_out, 32'h35);
		axi_wr(8'h40, 32'hFFFFFFFF);
		check(r, `RESP_SLVERR);
		check(brownout_threshold_out, 32'h35);
		axi_rd(8'h40);
		check(r, `RESP_SLVERR);
		check(d, 32'h0);
	endtask

	task automatic xtal_test();
		axi_wr(`REG_CTRL, 32'h00000017);
		cycles(3);
		check(crystal_enable_out, 32'h0);
		check(crystal_div2_out, 32'h1);
		cpu_booted_in <= 1'b1;
		cycles(3);
		check(crystal_enable_out, 32'h1);
		for (int i = 0; i < 6; i++)
		begin
			axi_wr(`REG_CTRL, {27'h0, 3'(i), 2'b01});
			check(osc_select_out, i);
			check(crystal_div2_out, 32'h0);
		end
	endtask

	task automatic ext_reset_test();
		ext_pull <= 1'b1;
		cycles(2);
		check(chip_reset_out, 32'h1);
		cpu_booted_in <= 1'b0;
		otp_load_done_in <= 1'b0;
		cycles(4);
		ext_pull <= 1'b0;
		cycles(2);
		brownout_detector_in <= 2'h1;
		cycles(5);
		brownout_detector_in <= 2'h0;
		cycles(2);
		check(chip_reset_out, 32'h1);
		while (chip_reset_out !== 1'b0)
			@(posedge sys_clk_in);
		check(crystal_enable_out, 32'h0);
		check(osc_select_out, 32'h5);
		check(osc_trim_out, 32'h12345678);
		reboot();
	endtask

	task automatic supply_test();
		main_supply_ok_in <= 1'b0;
		cycles(8);
		check(chip_reset_line_n_out, 32'h0);
		check(chip_reset_out, 32'h1);
		main_supply_ok_in <= 1'b1;
		cpu_booted_in <= 1'b0;
		otp_load_done_in <= 1'b0;
		cycles(4);
		check(chip_reset_out, 32'h1);
		reboot();
	endtask

	task automatic bod_test();
		axi_wr(`REG_STATUS, 32'h00000001);
		axi_wr(`REG_CTRL, 32'h00000100);
		brownout_detector_in <= 2'h2;
		cycles(6);
		check(chip_reset_out, 32'h0);
		brownout_detector_in <= 2'h0;
		cycles(5);
		axi_rd(`REG_STATUS);
		check(d[0], 32'h1);
		axi_wr(`REG_STATUS, 32'h00000001);
		axi_rd(`REG_STATUS);
		check(d[0], 32'h0);
	endtask

	// Firmware reset: short own pull, full stretch, self-clearing bit
	task automatic sw_reset_test();
		axi_wr(`REG_CTRL, 32'h80000000);
		cycles(2);
		check(chip_reset_out, 32'h1);
		check(chip_reset_line_n_oe_out, 32'h1);
		cycles(3);
		check(chip_reset_line_n_out, 32'h1);
		check(chip_reset_out, 32'h1);
		axi_rd(`REG_CTRL);
		check(d, 32'h0);
		reboot();
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Watchdog
	initial
	begin
		#1000000;
		err_count++;
		final_report();
	end

	// Main sequence
	initial
	begin
		cycles(3);
		rst_in <= 1'b0;
		powerup_test();
		regs_test();
		xtal_test();
		ext_reset_test();
		supply_test();
		bod_test();
		sw_reset_test();
		final_report();
	end
endmodule

`default_nettype wire
